//--- fbfc_ctrl.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
// Contract
// RL1: 64-byte queue behind one byte port; write pushes, read pops.
// RL2: queue buffers host bytes and internal serial transmit/receive streams.
// RL3: read-only 7-bit fill count, up on push, down on pop.
// RL4: flush bit resets pointers and overflow flag; reads zero.
// RL5: 6-bit threshold, reset 08h, upper two bits reserved.
// RL6: near-full when free space is at most the threshold.
// RL7: near-empty when stored bytes are at most the threshold.
// RL8: timer-halt bit writes a stop pulse; reads zero.
// RL9: timer-launch bit writes a start pulse; reads zero.
// RL10: copy-identifier bit loads ten stored bytes into queue, then self-clears.
// RL11: role bit: one for initiator, zero for target.
// RL12: read-only count of valid bits in last received byte.
// RL13: transmit trigger starts sending only while exchange command active.
// RL14: receive offset places first received bit, later bits wrap.
// RL15: software keeps receive offset zero except bitwise anticollision.
// RL16: 3-bit count of final-byte bits to send; zero means all.
// RL17: modem phase reads 001 while waiting for transmit trigger.
// RL18: push when full is dropped and flags overflow; empty pop ignored.
module fbfc_ctrl
(
  input  wire logic        sys_clk,        // system clock
  input  wire logic        rst_b,          // async reset, active low
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb direction
  input  wire logic [5:0]  paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic      [31:0] prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb error
  output logic             irq,            // level interrupt
  input  wire logic        rxPush,         // receive path pushes a byte
  input  wire logic [7:0]  rxByte,         // received byte
  input  wire logic [2:0]  rxFinalValidBits, // valid bits of last rx byte
  input  wire logic        txPop,          // transmit path pops a byte
  input  wire logic        txDone,         // transmit path finished
  output logic      [7:0]  txByte,         // head byte of queue
  output logic             txHasData,      // queue not empty
  output logic             txStart,        // transmit start pulse
  output logic             timerHaltStrobe,   // timer stop pulse
  output logic             timerLaunchStrobe, // timer start pulse
  output logic             roleInitiator,  // initiator role
  output logic      [2:0]  rxBitOffset,    // receive bit offset
  output logic      [2:0]  txFinalBitCount, // bits of final tx byte
  output logic      [2:0]  modemPhase      // modem phase
);

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [7:0]              mem_q [fbfc_pkg::DEPTH];
  logic [fbfc_pkg::PTR_W-1:0] rdPtr_q, wrPtr_q;
  logic [fbfc_pkg::CNT_W-1:0] fillCount_q;
  logic                    overflow_q;
  logic [5:0]              threshold_q;
  logic                    role_q;
  logic [2:0]              rxOffset_q, txBits_q, rxValid_q;
  logic                    exchange_q;
  logic                    copyBusy_q;
  logic [3:0]              copyIdx_q;
  logic [fbfc_pkg::IRQ_W-1:0] irqStat_q, irqMask_q;
  logic [31:0]             prdata_q;
  logic                    pready_q, haltS_q, launchS_q, txStart_q;
  fbfc_pkg::fbfc_tx_t      txState_q;
  logic [2:0]              phase_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire        setup     = psel && !penable;
  wire [3:0]  regIdx    = paddr[5:2];
  wire        wr        = setup && pwrite;
  wire        rd        = setup && !pwrite;
  wire        wrData    = wr && (regIdx == fbfc_pkg::IDX_DATA);
  wire        rdData    = rd && (regIdx == fbfc_pkg::IDX_DATA);
  wire        wrLevel   = wr && (regIdx == fbfc_pkg::IDX_LEVEL);
  wire        wrThresh  = wr && (regIdx == fbfc_pkg::IDX_THRESH);
  wire        wrCtrl    = wr && (regIdx == fbfc_pkg::IDX_CTRL);
  wire        wrFrame   = wr && (regIdx == fbfc_pkg::IDX_FRAME);
  wire        wrStat    = wr && (regIdx == fbfc_pkg::IDX_IRQSTAT);
  wire        wrMask    = wr && (regIdx == fbfc_pkg::IDX_IRQMASK);
  wire        wrExch    = wr && (regIdx == fbfc_pkg::IDX_EXCHANGE);
  wire        mapped    = (regIdx >= fbfc_pkg::IDX_EXCHANGE);
  wire        flush     = wrLevel && pwdata[fbfc_pkg::BIT_FLUSH];           // RL4
  wire        startCopy = wrCtrl && pwdata[fbfc_pkg::BIT_COPYID] && !copyBusy_q;

  // ----------------------------------------------------------------
  // queue push/pop arbitration
  // ----------------------------------------------------------------
  // one push source per cycle: host, then identifier copy, then receive path
  wire        full      = (fillCount_q == fbfc_pkg::DEPTH_CNT);
  wire        empty     = (fillCount_q == '0);
  wire        pushReq   = wrData || copyBusy_q || rxPush;                   // RL2
  wire [7:0]  idByte    = fbfc_pkg::ID_DEFAULT[{copyIdx_q, 3'h0} +: 8];
  wire [7:0]  pushByte  = wrData ? pwdata[7:0] : (copyBusy_q ? idByte : rxByte);
  wire        doPush    = pushReq && !full && !flush;                       // RL18
  wire        popReq    = rdData || (txPop && !rdData);                     // RL2
  wire        doPop     = popReq && !empty && !flush;                       // RL18
  wire        ovfEvent  = pushReq && full && !flush;                        // RL18
  wire        nearFull  = ((fbfc_pkg::DEPTH_CNT - fillCount_q) <= {1'b0, threshold_q}); // RL6
  wire        nearEmpty = (fillCount_q <= {1'b0, threshold_q});             // RL7
  wire [fbfc_pkg::IRQ_W-1:0] irqEvent = {nearEmpty, nearFull, ovfEvent};
  wire [fbfc_pkg::CNT_W-1:0] fillNext =
    fillCount_q + {6'h00, doPush} - {6'h00, doPop};                         // RL3

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0]  ctrlRd  = {3'h0, role_q, 1'b0, rxValid_q};                    // RL8 RL9 RL12
  wire [7:0]  frameRd = {1'b0, rxOffset_q, 1'b0, txBits_q};                 // RL13
  wire [7:0]  rdByte  =
    (regIdx == fbfc_pkg::IDX_DATA)    ? mem_q[rdPtr_q] :                    // RL1
    (regIdx == fbfc_pkg::IDX_LEVEL)   ? {1'b0, fillCount_q} :               // RL4 RL3
    (regIdx == fbfc_pkg::IDX_THRESH)  ? {2'h0, threshold_q} :               // RL5
    (regIdx == fbfc_pkg::IDX_CTRL)    ? ctrlRd :
    (regIdx == fbfc_pkg::IDX_FRAME)   ? frameRd :
    (regIdx == fbfc_pkg::IDX_IRQSTAT) ? {5'h00, irqStat_q} :
    (regIdx == fbfc_pkg::IDX_IRQMASK) ? {5'h00, irqMask_q} :
    (regIdx == fbfc_pkg::IDX_EXCHANGE)? {7'h00, exchange_q} : 8'h00;

  // ----------------------------------------------------------------
  // apb slave: one wait-free access phase
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr  <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      pslverr  <= setup && !mapped;
      // writes and unmapped reads return zero so stale data never leaks
      if (setup)
        prdata_q <= {24'h000000, (rd && mapped) ? rdByte : 8'h00};
    end
  end

  // ----------------------------------------------------------------
  // queue storage
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (doPush)
      mem_q[wrPtr_q] <= pushByte;                                           // RL1
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdPtr_q     <= '0;
      wrPtr_q     <= '0;
      fillCount_q <= '0;
      overflow_q  <= 1'b0;
    end
    else if (flush)
    begin
      rdPtr_q     <= '0;                                                    // RL4
      wrPtr_q     <= '0;
      fillCount_q <= '0;
      overflow_q  <= 1'b0;
    end
    else
    begin
      if (doPush)
        wrPtr_q <= wrPtr_q + 6'h01;
      if (doPop)
        rdPtr_q <= rdPtr_q + 6'h01;
      fillCount_q <= fillNext;                                              // RL3
      if (ovfEvent)
        overflow_q <= 1'b1;                                                 // RL18
    end
  end

  // ----------------------------------------------------------------
  // configuration and identifier copy
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      threshold_q <= fbfc_pkg::THRESH_RST;                                  // RL5
      role_q      <= 1'b0;
      rxOffset_q  <= '0;
      txBits_q    <= '0;
      rxValid_q   <= '0;
      exchange_q  <= 1'b0;
      copyBusy_q  <= 1'b0;
      copyIdx_q   <= '0;
    end
    else
    begin
      if (wrThresh)
        threshold_q <= pwdata[5:0];                                         // RL5
      if (wrCtrl)
        role_q <= pwdata[fbfc_pkg::BIT_ROLE];                               // RL11
      if (wrFrame)
      begin
        rxOffset_q <= pwdata[6:4];                                          // RL14
        txBits_q   <= pwdata[2:0];                                          // RL16
      end
      if (wrExch)
        exchange_q <= pwdata[0];
      if (rxPush)
        rxValid_q <= rxFinalValidBits;                                      // RL12
      if (startCopy)
      begin
        copyBusy_q <= 1'b1;                                                 // RL10
        copyIdx_q  <= '0;
      end
      else if (copyBusy_q && !wrData && !full)
      begin
        copyIdx_q <= copyIdx_q + 4'h1;
        if (copyIdx_q == fbfc_pkg::ID_LAST)
          copyBusy_q <= 1'b0;                                               // RL10
      end
    end
  end

  // ----------------------------------------------------------------
  // strobes and transmit phase
  // ----------------------------------------------------------------
  wire trigger = wrFrame && pwdata[fbfc_pkg::BIT_TRIGGER];

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      haltS_q   <= 1'b0;
      launchS_q <= 1'b0;
      txStart_q <= 1'b0;
      txState_q <= fbfc_pkg::ST_IDLE;
      phase_q   <= fbfc_pkg::PHASE_IDLE;
    end
    else
    begin
      haltS_q   <= wrCtrl && pwdata[fbfc_pkg::BIT_HALT];                    // RL8
      launchS_q <= wrCtrl && pwdata[fbfc_pkg::BIT_LAUNCH];                  // RL9
      txStart_q <= 1'b0;
      case (txState_q)
        fbfc_pkg::ST_IDLE:
        begin
          phase_q <= fbfc_pkg::PHASE_IDLE;
          if (exchange_q)
          begin
            txState_q <= fbfc_pkg::ST_WAITTX;
            phase_q   <= fbfc_pkg::PHASE_WAITTX;                            // RL17
          end
        end
        fbfc_pkg::ST_WAITTX:
        begin
          if (!exchange_q)
          begin
            txState_q <= fbfc_pkg::ST_IDLE;
            phase_q   <= fbfc_pkg::PHASE_IDLE;
          end
          else if (trigger)
          begin
            txStart_q <= 1'b1;                                              // RL13
            txState_q <= fbfc_pkg::ST_SEND;
            phase_q   <= fbfc_pkg::PHASE_SEND;
          end
        end
        fbfc_pkg::ST_SEND:
        begin
          if (txDone || !exchange_q)
          begin
            txState_q <= fbfc_pkg::ST_IDLE;
            phase_q   <= fbfc_pkg::PHASE_IDLE;
          end
        end
        default:
          txState_q <= fbfc_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  logic irq_q;
  logic [7:0] txByte_q;
  logic txHas_q;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqStat_q <= '0;
      irqMask_q <= '0;
      irq_q     <= 1'b0;
      txByte_q  <= '0;
      txHas_q   <= 1'b0;
    end
    else
    begin
      irqStat_q <= (irqStat_q & ~(wrStat ? pwdata[2:0] : 3'h0)) | irqEvent;
      if (wrMask)
        irqMask_q <= pwdata[2:0];
      irq_q    <= |(irqStat_q & irqMask_q);
      txByte_q <= mem_q[rdPtr_q];
      txHas_q  <= !empty;
    end
  end

  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign irq               = irq_q;
  assign txByte            = txByte_q;
  assign txHasData         = txHas_q;
  assign txStart           = txStart_q;
  assign timerHaltStrobe   = haltS_q;
  assign timerLaunchStrobe = launchS_q;
  assign roleInitiator     = role_q;
  assign rxBitOffset       = rxOffset_q;
  assign txFinalBitCount   = txBits_q;
  assign modemPhase        = phase_q;

endmodule : fbfc_ctrl

//--- fbfc_ctrl_checker.sv
`timescale 1ns/1ps
module fbfc_ctrl_checker
(
  input wire logic        sys_clk,           // clock
  input wire logic        rst_b,             // reset, active low
  input wire logic        psel,              // apb select
  input wire logic        penable,           // apb enable
  input wire logic        pwrite,            // apb direction
  input wire logic [5:0]  paddr,             // apb address
  input wire logic [31:0] pwdata,            // apb write data
  input wire logic [31:0] prdata,            // apb read data
  input wire logic        pready,            // apb ready
  input wire logic        pslverr,           // apb error
  input wire logic        txStart,           // transmit start pulse
  input wire logic        timerHaltStrobe,   // timer stop pulse
  input wire logic        timerLaunchStrobe, // timer start pulse
  input wire logic        roleInitiator,     // role level
  input wire logic [2:0]  rxBitOffset,       // receive offset
  input wire logic [2:0]  txFinalBitCount,   // final byte bits
  input wire logic [2:0]  modemPhase         // modem phase
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_set(logic w, logic [3:0] i);
    psel && !penable && (pwrite == w) && (paddr[5:2] == i);
  endsequence

  a_ready_next: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single pulse after setup");
  a_err_unmap: assert property (psel && !penable && paddr[5:2] < 4'h8
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_halt_pulse: assert property (s_set(1, fbfc_pkg::IDX_CTRL) ##0 pwdata[7]
    |=> timerHaltStrobe ##1 !timerHaltStrobe) else $error("halt strobe wrong");
  a_launch_pulse: assert property (s_set(1, fbfc_pkg::IDX_CTRL) ##0 pwdata[6]
    |=> timerLaunchStrobe ##1 !timerLaunchStrobe) else $error("launch strobe wrong");
  a_role_set: assert property (s_set(1, fbfc_pkg::IDX_CTRL)
    |=> roleInitiator == $past(pwdata[4])) else $error("role not taken");
  a_frame_cfg: assert property (s_set(1, fbfc_pkg::IDX_FRAME)
    |=> rxBitOffset == $past(pwdata[6:4]) && txFinalBitCount == $past(pwdata[2:0]))
    else $error("framing fields not taken");
  a_flush_rdzero: assert property (s_set(0, fbfc_pkg::IDX_LEVEL)
    |=> prdata[7] == 1'b0) else $error("flush bit reads one");
  a_ctrl_rdzero: assert property (s_set(0, fbfc_pkg::IDX_CTRL)
    |=> prdata[7:5] == 3'h0) else $error("control strobes read one");
  a_thr_resv: assert property (s_set(0, fbfc_pkg::IDX_THRESH)
    |=> prdata[7:6] == 2'h0) else $error("reserved threshold bits set");
  a_start_wait: assert property ($rose(txStart)
    |-> $past(modemPhase) == fbfc_pkg::PHASE_WAITTX) else $error("start outside wait");
endmodule : fbfc_ctrl_checker

bind fbfc_ctrl fbfc_ctrl_checker u_chk (.*);

//--- fbfc_ctrl_test.sv
`timescale 1ns/1ps
module fbfc_ctrl_test;
  localparam logic [5:0] aData = {fbfc_pkg::IDX_DATA, 2'b00};
  localparam logic [5:0] aLevel = {fbfc_pkg::IDX_LEVEL, 2'b00};
  localparam logic [5:0] aThr = {fbfc_pkg::IDX_THRESH, 2'b00};
  localparam logic [5:0] aCtrl = {fbfc_pkg::IDX_CTRL, 2'b00};
  localparam logic [5:0] aFrame = {fbfc_pkg::IDX_FRAME, 2'b00};
  localparam logic [5:0] aStat = {fbfc_pkg::IDX_IRQSTAT, 2'b00};
  localparam logic [5:0] aMask = {fbfc_pkg::IDX_IRQMASK, 2'b00};
  localparam logic [5:0] aExch = {fbfc_pkg::IDX_EXCHANGE, 2'b00};
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, rxGo = 0;
  logic [5:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [7:0] rxData = '0, rxByte, txByte, sentByte, b;
  logic [2:0] rxBits = '0, rxFinalValidBits, rxBitOffset, txFinalBitCount, modemPhase;
  logic pready, pslverr, irq, rxPush, txPop, txDone, txHasData, txStart;
  logic timerHaltStrobe, timerLaunchStrobe, roleInitiator;
  logic [9:0] expQ[$];
  logic [7:0] mq[$];
  logic [9:0] e;
  int starts, nFail = 0, testsRun = 0, seed = 32'he94fd9b3;

  fbfc_ctrl uut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .rxPush(rxPush), .rxByte(rxByte),
    .rxFinalValidBits(rxFinalValidBits), .txPop(txPop), .txDone(txDone), .txByte(txByte),
    .txHasData(txHasData), .txStart(txStart), .timerHaltStrobe(timerHaltStrobe),
    .timerLaunchStrobe(timerLaunchStrobe), .roleInitiator(roleInitiator),
    .rxBitOffset(rxBitOffset), .txFinalBitCount(txFinalBitCount), .modemPhase(modemPhase));
  fbfc_far_model far (.sys_clk(sys_clk), .rst_b(rst_b), .rxGo(rxGo), .rxData(rxData),
    .rxBits(rxBits), .txStart(txStart), .txByte(txByte), .rxPush(rxPush), .rxByte(rxByte),
    .rxFinalValidBits(rxFinalValidBits), .txPop(txPop), .txDone(txDone),
    .sentByte(sentByte), .starts(starts));

  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [8:0] g, input logic [8:0] x);
    testsRun++;
    if (g !== x)
    begin
      nFail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge keeps the next setup off the edge that released this one
    @(posedge sys_clk);
  endtask : xfer

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [8:0] x);
    expQ.push_back({1'b0, x});
    xfer(1'b0, a, 8'h00);
  endtask : rd

  task automatic fill(input int n);
    logic [7:0] d;
    repeat (n)
    begin
      d = 8'($random(seed));
      if (mq.size() < fbfc_pkg::DEPTH)
        mq.push_back(d);
      wr(aData, d);
    end
  endtask : fill

  task automatic pop1();
    rd(aData, {1'b0, mq.pop_front()});
  endtask : pop1

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // read results are matched against the oldest note
  always @(posedge sys_clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      e = expQ.pop_front();
      if (!e[9])
        chk({pslverr, prdata[7:0]}, e[8:0]);
    end
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    nFail++;
    summarize();
  end

  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(aLevel, 9'h000);
    rd(aCtrl, 9'h000);
    rd(aFrame, 9'h000);
    rd(6'h04, 9'h100);
    rd(aThr, 9'h008);
    wr(aThr, 8'hc4);
    rd(aThr, 9'h004);
    fill(5);
    wr(aStat, 8'h07);
    rd(aStat, 9'h000);
    pop1();
    rd(aLevel, 9'h004);
    rd(aStat, 9'h004);
    fill(55);
    wr(aStat, 8'h07);
    rd(aStat, 9'h000);
    fill(1);
    rd(aStat, 9'h002);
    fill(5);
    rd(aLevel, 9'h040);
    rd(aStat, 9'h003);
    chk({8'h0, irq}, 9'h000);
    wr(aMask, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk({8'h0, irq}, 9'h001);
    wr(aStat, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk({8'h0, irq}, 9'h000);
    repeat (64) pop1();
    rd(aLevel, 9'h000);
    expQ.push_back(10'h200);
    xfer(1'b0, aData, 8'h00);
    rd(aLevel, 9'h000);
    fill(3);
    wr(aLevel, 8'h80);
    rd(aLevel, 9'h000);
    mq.delete();
    wr(aCtrl, 8'hd0);
    rd(aCtrl, 9'h010);
    wr(aCtrl, 8'h20);
    repeat (14) @(posedge sys_clk);
    rd(aLevel, 9'h00a);
    for (int i = 0; i < fbfc_pkg::ID_BYTES; i++)
      rd(aData, {1'b0, fbfc_pkg::ID_DEFAULT[8*i +: 8]});
    rd(aCtrl, 9'h000);
    wr(aFrame, 8'h57);
    rd(aFrame, 9'h057);
    wr(aFrame, 8'h00);
    rxData <= 8'($random(seed));
    rxBits <= 3'h3;
    rxGo   <= 1'b1;
    @(posedge sys_clk);
    rxGo   <= 1'b0;
    mq.push_back(rxData);
    repeat (3) @(posedge sys_clk);
    rd(aLevel, 9'h001);
    pop1();
    rd(aCtrl, 9'h003);
    wr(aExch, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk({6'h0, modemPhase}, 9'h001);
    fill(1);
    chk({8'h0, txHasData}, 9'h001);
    b = mq.pop_front();
    wr(aFrame, 8'h80);
    repeat (8) @(posedge sys_clk);
    chk({1'b0, sentByte}, {1'b0, b});
    rd(aLevel, 9'h000);
    chk({8'h0, txHasData}, 9'h000);
    wr(aExch, 8'h00);
    wr(aFrame, 8'h80);
    repeat (8) @(posedge sys_clk);
    chk(9'(starts), 9'h001);
    summarize();
  end
endmodule : fbfc_ctrl_test

//--- fbfc_far_model.sv
`timescale 1ns/1ps
module fbfc_far_model
#(
  parameter int TX_LAG = 3 // cycles from start to pop
)
(
  input wire logic       sys_clk,          // clock
  input wire logic       rst_b,            // reset, active low
  input wire logic       rxGo,             // bench asks for one rx byte
  input wire logic [7:0] rxData,           // byte to deliver
  input wire logic [2:0] rxBits,           // valid bits to deliver
  input wire logic       txStart,          // start pulse from block
  input wire logic [7:0] txByte,           // head byte from block
  output logic           rxPush,           // rx push pulse
  output logic     [7:0] rxByte,           // rx byte
  output logic     [2:0] rxFinalValidBits, // rx valid bits
  output logic           txPop,            // tx pop pulse
  output logic           txDone,           // tx finished pulse
  output logic     [7:0] sentByte,         // last byte taken
  output int             starts            // starts seen
);
  int txCnt;

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {rxPush, rxByte, rxFinalValidBits, txPop, txDone, sentByte} <= '0;
      starts <= 0;
      txCnt  <= 0;
    end
    else
    begin
      // data lines are scrambled outside a push
      rxPush           <= rxGo;
      rxByte           <= rxGo ? rxData : ~rxByte;
      rxFinalValidBits <= rxGo ? rxBits : ~rxFinalValidBits;
      txPop            <= (txCnt == 2);
      txDone           <= (txCnt == 1);
      if (txCnt == 2)
        sentByte <= txByte;
      if (txStart)
      begin
        txCnt  <= TX_LAG;
        starts <= starts + 1;
      end
      else if (txCnt != 0)
        txCnt <= txCnt - 1;
    end
  end
endmodule : fbfc_far_model

//--- fbfc_pkg.sv
package fbfc_pkg;
  // register indices (printed offsets are not all multiples of four)
  localparam logic [3:0] IDX_DATA      = 4'h9;
  localparam logic [3:0] IDX_LEVEL     = 4'ha;
  localparam logic [3:0] IDX_THRESH    = 4'hb;
  localparam logic [3:0] IDX_CTRL      = 4'hc;
  localparam logic [3:0] IDX_FRAME     = 4'hd;
  localparam logic [3:0] IDX_IRQSTAT   = 4'he;
  localparam logic [3:0] IDX_IRQMASK   = 4'hf;
  localparam logic [3:0] IDX_EXCHANGE  = 4'h8;

  localparam int         DEPTH         = 64;
  localparam int         PTR_W         = 6;
  localparam int         CNT_W         = 7;
  localparam int         ID_BYTES      = 10;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 7'h40;
  localparam logic [3:0] ID_LAST       = 4'h9;

  localparam logic [5:0] THRESH_RST    = 6'h08;
  localparam int         BIT_FLUSH     = 7;
  localparam int         BIT_HALT      = 7;
  localparam int         BIT_LAUNCH    = 6;
  localparam int         BIT_COPYID    = 5;
  localparam int         BIT_ROLE      = 4;
  localparam int         BIT_TRIGGER   = 7;

  // interrupt status layout
  localparam int         IRQ_OVF       = 0;
  localparam int         IRQ_NFULL     = 1;
  localparam int         IRQ_NEMPTY    = 2;
  localparam int         IRQ_W         = 3;

  localparam logic [2:0] PHASE_IDLE    = 3'h0;
  localparam logic [2:0] PHASE_WAITTX  = 3'h1;
  localparam logic [2:0] PHASE_SEND    = 3'h3;

  // identifier content is arbitrary
  localparam logic [79:0] ID_DEFAULT   = 80'h0123456789abcdef0011;

  typedef enum logic [1:0] {ST_IDLE, ST_WAITTX, ST_SEND} fbfc_tx_t;
endpackage : fbfc_pkg
